// ===== tb/low_power_mode_controller_tb.sv
// Purpose: self-checking bench for lpm_ctrl
// Assumes: zero wait state slave
// Notes: hrdata taken at the edge ending the data phase
`timescale 1ns/10ps
`include "lpm_defs.vh"
`define CHK(a,e) begin samples_checked++; if ((a) !== (e)) begin \
 failures++; $display("mismatch %0t %h %h", $time, a, e); end end
`define WT(c) begin n = 0; while (!(c) && n < 300) begin \
 @(posedge ref_clk); #1; n++; end if (n >= 300) stop_run; end
module low_power_mode_controller_tb;
   localparam [11:0] pc_a = `LPM_ADDR_POWER_CONTROL;
   localparam [11:0] ip_a = `LPM_ADDR_IDLE_PEND;
   localparam [11:0] sp_a = `LPM_ADDR_STOP_PEND;
   localparam [11:0] cc_a = `LPM_ADDR_CLOCK_CONTROL;
   reg ref_clk, reset, hsel, hwrite, irq_req;
   reg clk_mon_wake, any_reset_event, emul_mode_in, wdt_enabled;
   reg [11:0] haddr;
   reg [1:0] htrans;
   reg [2:0] hsize;
   reg [31:0] hwdata, q;
   reg [6:0] idle_pend_in, stop_wake_in;
   wire hreadyout, hresp, any_irq, cpu_halt, sys_clk_en, osc_gen_en;
   wire keep_tick_osc, irq_grant, soft_reset_pulse, mem_ctrl_reset_hold;
   wire sys_clk_select;
   wire [31:0] hrdata;
   int failures, samples_checked, n, k;
   lpm_ctrl dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .idle_pend_in(idle_pend_in),
      .stop_wake_in(stop_wake_in), .clk_mon_wake(clk_mon_wake),
      .any_irq(any_irq), .any_reset_event(any_reset_event),
      .emul_mode_in(emul_mode_in), .wdt_enabled(wdt_enabled),
      .tick_enabled(1'b0), .cpu_halt(cpu_halt), .sys_clk_en(sys_clk_en),
      .osc_gen_en(osc_gen_en), .keep_tick_osc(keep_tick_osc),
      .irq_grant(irq_grant), .soft_reset_pulse(soft_reset_pulse),
      .mem_ctrl_reset_hold(mem_ctrl_reset_hold),
      .sys_clk_select(sys_clk_select));
   lpm_cpu_model cpu (.ref_clk(ref_clk), .reset(reset),
      .irq_req(irq_req), .irq_grant(irq_grant), .any_irq(any_irq));
   task give_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task stop_run;
      failures++;
      give_verdict;
   endtask
   task hold_rdy;
      for (n = 0; hreadyout !== 1'b1 && n < 300; n++) @(posedge ref_clk);
      if (n >= 300) stop_run;
   endtask
   task bus(input bit w, input [11:0] a, input [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge ref_clk);
      hold_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      hold_rdy;
      q = hrdata;
      hsel <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   task t_regs;
      bus(0, pc_a, 0); `CHK(q, 32'h0)
      bus(0, ip_a, 0); `CHK(q, 32'h0)
      bus(0, sp_a, 0); `CHK(q, 32'h0)
      bus(1, 12'h000, 32'hff);
      bus(0, 12'h000, 0); `CHK(q, 32'h0)
      bus(1, pc_a, 32'hd8);
      bus(0, pc_a, 0); `CHK(q, 32'h0)
      bus(1, cc_a, 32'h1); `CHK(sys_clk_select, 1'b1)
      bus(0, cc_a, 0); `CHK(q, 32'h1)
      bus(1, cc_a, 32'h0);
   endtask
   task t_idle;
      @(posedge ref_clk);
      idle_pend_in <= 7'h5a;
      repeat (2) @(posedge ref_clk);
      bus(0, ip_a, 0); `CHK(q, 32'h5a)
      bus(1, pc_a, 32'h1);
      bus(0, pc_a, 0); `CHK(cpu_halt, 1'b0)
      `CHK(q, 32'h0)
      idle_pend_in <= 7'h0;
      repeat (3) @(posedge ref_clk);
      bus(1, pc_a, 32'h1);
      repeat (2) @(posedge ref_clk); // two nops
      `WT(cpu_halt === 1'b1) `CHK(sys_clk_en, 1'b1)
      bus(0, pc_a, 0); `CHK(q, 32'h1)
      irq_req <= 1'b1;
      @(posedge ref_clk);
      irq_req <= 1'b0;
      `WT(irq_grant === 1'b1) `CHK(sys_clk_en, 1'b1)
      bus(0, pc_a, 0); `CHK({q, cpu_halt}, 33'h0)
   endtask
   task t_stop;
      @(posedge ref_clk);
      stop_wake_in <= 7'h40;
      wdt_enabled <= 1'b1;
      repeat (2) @(posedge ref_clk);
      bus(1, cc_a, 32'h1); // low speed rc kept before stop
      `CHK(sys_clk_select, 1'b1)
      bus(0, sp_a, 0); `CHK(q, 32'h40)
      bus(1, pc_a, 32'h2);
      repeat (6) @(posedge ref_clk);
      #1 `CHK(sys_clk_en, 1'b1)
      stop_wake_in <= 7'h0;
      for (k = 0; k < 9; k++) begin
         bus(1, pc_a, k == 0 ? 32'h3 : 32'h2); // both bits once
         repeat (3) @(posedge ref_clk); // three nops
         `WT(sys_clk_en === 1'b0) @(posedge ref_clk);
         #1 `CHK({cpu_halt, osc_gen_en, keep_tick_osc}, 3'h5)
         @(posedge ref_clk);
         if (k < 7) stop_wake_in <= 7'h1 << k;
         else if (k == 7) clk_mon_wake <= 1'b1;
         else any_reset_event <= 1'b1;
         `WT(sys_clk_en === 1'b1) `WT(cpu_halt === 1'b0)
         @(posedge ref_clk);
         {stop_wake_in, clk_mon_wake, any_reset_event} <= '0;
         repeat (3) @(posedge ref_clk);
         bus(0, pc_a, 0); `CHK(q, 32'h0)
      end
   endtask
   task t_soft_reset_request;
      bus(1, pc_a, 32'h20);
      `WT(soft_reset_pulse === 1'b1) `CHK(mem_ctrl_reset_hold, 1'b1)
      bus(0, pc_a, 0); `CHK(q, 32'h0)
      emul_mode_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bus(0, pc_a, 0); `CHK(q, 32'h4)
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      reset = 1'b1;
      {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
      {idle_pend_in, stop_wake_in, clk_mon_wake, irq_req} = '0;
      {any_reset_event, emul_mode_in, wdt_enabled} = '0;
      hsize = 3'h2;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs;
      t_idle;
      t_stop;
      t_soft_reset_request;
      give_verdict;
   end
endmodule

// ===== tb/lpm_cpu_model.sv
// Purpose: interrupt source on the cpu side
// Assumes: request held until served
// Notes: drops request on grant
`timescale 1ns/10ps
module lpm_cpu_model (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // handshake
   input wire irq_req,
   input wire irq_grant,
   output reg any_irq
);
   always @(posedge ref_clk) begin
      if (reset)
         any_irq <= 1'b0;
      else if (irq_grant)
         any_irq <= 1'b0;
      else if (irq_req)
         any_irq <= 1'b1;
   end
endmodule

// ===== tb/lpm_ctrl_monitor.sv
// Purpose: port checker for lpm_ctrl
// Assumes: one clock domain, sync reset
// Notes: bound to every lpm_ctrl
`timescale 1ns/10ps
module lpm_ctrl_monitor (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // watched outputs
   input wire hreadyout,
   input wire hresp,
   input wire cpu_halt,
   input wire sys_clk_en,
   input wire osc_gen_en,
   input wire keep_tick_osc,
   input wire irq_grant,
   input wire soft_reset_pulse,
   input wire mem_ctrl_reset_hold
);
   // ========================
   // wake steps
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence s_clk_back;
      $rose(sys_clk_en);
   endsequence
   sequence s_run_after;
      ##1 (!irq_grant && !cpu_halt);
   endsequence
   // ========================
   // checks
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   a_off_halted: assert property (!sys_clk_en |-> cpu_halt)
      else $error("clock off while cpu runs");
   a_osc_pair: assert property (sys_clk_en == osc_gen_en)
      else $error("generators not off with clock");
   a_tick_stop: assert property (keep_tick_osc |-> !osc_gen_en)
      else $error("tick oscillator kept outside stop");
   a_stop_last: assert property ($fell(sys_clk_en) |-> $past(cpu_halt))
      else $error("clock stopped before halt");
   a_restore_first: assert property (s_clk_back |-> cpu_halt)
      else $error("cpu ran before clock restored");
   a_grant_clock: assert property (
      irq_grant |-> sys_clk_en && $past(sys_clk_en))
      else $error("interrupt served without clock");
   a_grant_pulse: assert property (irq_grant |-> s_run_after)
      else $error("grant not a single pulse");
   a_soft_reset_request_pulse: assert property (
      soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset longer than a cycle");
   a_mem_spared: assert property (
      soft_reset_pulse |-> mem_ctrl_reset_hold)
      else $error("memory control not spared");
endmodule
bind lpm_ctrl lpm_ctrl_monitor mon (.ref_clk(ref_clk), .reset(reset),
   .hreadyout(hreadyout), .hresp(hresp), .cpu_halt(cpu_halt),
   .sys_clk_en(sys_clk_en), .osc_gen_en(osc_gen_en),
   .keep_tick_osc(keep_tick_osc), .irq_grant(irq_grant),
   .soft_reset_pulse(soft_reset_pulse),
   .mem_ctrl_reset_hold(mem_ctrl_reset_hold));

// ===== verilog/lpm_ahb_slave.v
// Purpose: ahb-lite slave front end, zero wait states
// Assumes: single word transfers only
// Notes: gives one-cycle write strobe in the data phase
`timescale 1ns/10ps
module lpm_ahb_slave (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // ahb-lite
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   // register side
   output reg wr_en,
   output reg [11:0] wr_addr,
   output reg rd_en,
   output reg [11:0] rd_addr
);
   wire take;

   assign take = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always @(posedge ref_clk) begin
      if (reset) begin
         wr_en <= 1'b0;
         rd_en <= 1'b0;
         wr_addr <= 12'h000;
         rd_addr <= 12'h000;
      end else begin
         wr_en <= take & hwrite;
         rd_en <= take & ~hwrite;
         if (take) begin
            wr_addr <= haddr;
            rd_addr <= haddr;
         end
      end
   end
endmodule

// ===== verilog/lpm_ctrl.v
// Contract
// - idle halts cpu; master clock and enabled peripherals keep running
// - idle request ignored while any idle pending bit is set
// - any reset or interrupt wakes from idle
// - interrupt wake: clock restored first, then cpu serves interrupt
// - idle bit 0 enters idle only if pending zero; clears on exit
// - stop halts all clocks except enabled watchdog or tick oscillators
// - stop bit 1 enters stop only if stop pending is zero
// - stop exits on external, lvd, tick, watchdog, clock monitor, touch
// - stop bit clears itself on stop exit
// - system clock switched off at final edge, then fully stopped
// - soft reset bit 5 generates reset then clears itself
// - read-only bit 2 shows online emulation mode
// - power control at 87h, reset 0, bits 7,6,4,3 unused
// - idle pending status at 8eh, bits 0..6 interrupt groups
// - stop pending status at 8fh, bits 0..6 wake groups
// - clock control bit 0 selects high (0) or low (1) speed rc
// - resets restart cpu at 0; soft reset spares memory control
//
// Purpose: low power mode controller, idle and stop sequencing
// Assumes: pending and wake inputs are levels from other clock logic
// Notes: registers reached over ahb-lite; byte address is 4x index
`timescale 1ns/10ps
`include "lpm_defs.vh"
module lpm_ctrl #(
   parameter STOP_OFF_CYCLES = `LPM_STOP_OFF_CYCLES,
   parameter RESTORE_CYCLES = `LPM_RESTORE_CYCLES,
   parameter SOFT_RESET_REQUEST_CYCLES = `LPM_SOFT_RESET_REQUEST_CYCLES
) (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // ahb-lite
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // interrupt and wake sources
   input wire [6:0] idle_pend_in,
   input wire [6:0] stop_wake_in,
   input wire clk_mon_wake,
   input wire any_irq,
   input wire any_reset_event,
   input wire emul_mode_in,
   input wire wdt_enabled,
   input wire tick_enabled,
   // core and clock generator controls
   output reg cpu_halt,
   output reg sys_clk_en,
   output reg osc_gen_en,
   output reg keep_tick_osc,
   output reg irq_grant,
   output reg soft_reset_pulse,
   output reg mem_ctrl_reset_hold,
   output reg sys_clk_select
);
   localparam ST_RUN = 3'd0;
   localparam ST_IDLE = 3'd1;
   localparam ST_STOP_OFF = 3'd2;
   localparam ST_STOP = 3'd3;
   localparam ST_RESTORE = 3'd4;

   wire wr_en;
   wire rd_en;
   wire [11:0] wr_addr;
   wire [11:0] rd_addr;
   wire [6:0] idle_pend_s;
   wire [6:0] stop_wake_s;
   wire [3:0] misc_s;
   wire emul_s;
   wire clkmon_s;
   wire irq_s;
   wire rst_ev_s;
   wire pc_wr;
   wire idle_ok;
   wire stop_ok;
   wire stop_wake;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg idle_bit_ff;
   reg stop_bit_ff;
   reg soft_reset_request_bit_ff;
   reg sck_sel_ff;
   reg [7:0] cnt_ff;
   reg [7:0] nxt_cnt;
   reg [7:0] rd_byte;

   lpm_ahb_slave u_bus (
      .ref_clk(ref_clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .rd_en(rd_en),
      .rd_addr(rd_addr)
   );

   lpm_sync2 #(.WIDTH(18)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .async_in({idle_pend_in, stop_wake_in, emul_mode_in, clk_mon_wake,
                 any_irq, any_reset_event}),
      .sync_out({idle_pend_s, stop_wake_s, misc_s})
   );
   assign emul_s = misc_s[3];
   assign clkmon_s = misc_s[2];
   assign irq_s = misc_s[1];
   assign rst_ev_s = misc_s[0];

   // ==========================================================
   // entry conditions and stop wake
   assign pc_wr = wr_en & (wr_addr == `LPM_ADDR_POWER_CONTROL);
   assign idle_ok = hwdata[`LPM_BIT_IDLE] & ~(|idle_pend_s);
   assign stop_ok = hwdata[`LPM_BIT_STOP] & ~(|stop_wake_s);
   assign stop_wake = (|stop_wake_s) | clkmon_s | rst_ev_s;

   // ==========================================================
   // mode state machine
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         ST_RUN: begin
            if (pc_wr & stop_ok & ~soft_reset_request_bit_ff) begin
               nxt_state = ST_STOP_OFF;
               nxt_cnt = STOP_OFF_CYCLES[7:0];
            end else if (pc_wr & idle_ok & ~soft_reset_request_bit_ff) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (irq_s | rst_ev_s | (|idle_pend_s)) begin
               nxt_state = ST_RESTORE;
               nxt_cnt = RESTORE_CYCLES[7:0];
            end
         end
         ST_STOP_OFF: begin
            if (cnt_ff <= 8'h01) begin
               nxt_state = ST_STOP;
            end else begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         ST_STOP: begin
            if (stop_wake) begin
               nxt_state = ST_RESTORE;
               nxt_cnt = RESTORE_CYCLES[7:0];
            end
         end
         ST_RESTORE: begin
            if (cnt_ff <= 8'h01) begin
               nxt_state = ST_RUN;
            end else begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         default: begin
            nxt_state = ST_RUN;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         state_ff <= ST_RUN;
         cnt_ff <= 8'h00;
      end else if (soft_reset_pulse) begin
         state_ff <= ST_RUN;
         cnt_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // ==========================================================
   // power control and clock control bits
   always @(posedge ref_clk) begin
      if (reset) begin
         idle_bit_ff <= 1'b0;
         stop_bit_ff <= 1'b0;
         soft_reset_request_bit_ff <= 1'b0;
         sck_sel_ff <= 1'b0;
      end else begin
         if (state_ff == ST_RUN && nxt_state == ST_IDLE) begin
            idle_bit_ff <= 1'b1;
         end else if (state_ff == ST_RESTORE && nxt_state == ST_RUN) begin
            idle_bit_ff <= 1'b0;
         end
         if (state_ff == ST_RUN && nxt_state == ST_STOP_OFF) begin
            stop_bit_ff <= 1'b1;
         end else if (state_ff == ST_RESTORE && nxt_state == ST_RUN) begin
            stop_bit_ff <= 1'b0;
         end
         if (soft_reset_pulse) begin
            soft_reset_request_bit_ff <= 1'b0;
         end else if (pc_wr & hwdata[`LPM_BIT_SOFT_RESET_REQUEST]) begin
            soft_reset_request_bit_ff <= 1'b1;
         end
         if (wr_en && wr_addr == `LPM_ADDR_CLOCK_CONTROL) begin
            sck_sel_ff <= hwdata[`LPM_BIT_SCKSEL];
         end
      end
   end

   // ==========================================================
   // soft reset generator
   always @(posedge ref_clk) begin
      if (reset) begin
         soft_reset_pulse <= 1'b0;
      end else if (soft_reset_pulse) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= soft_reset_request_bit_ff;
      end
   end

   // ==========================================================
   // core and clock outputs
   always @(posedge ref_clk) begin
      if (reset) begin
         cpu_halt <= 1'b0;
         sys_clk_en <= 1'b1;
         osc_gen_en <= 1'b1;
         keep_tick_osc <= 1'b0;
         irq_grant <= 1'b0;
         mem_ctrl_reset_hold <= 1'b0;
         sys_clk_select <= 1'b0;
      end else begin
         // idle halts core only, clock stays on
         cpu_halt <= (nxt_state != ST_RUN);
         sys_clk_en <= (nxt_state != ST_STOP);
         osc_gen_en <= (nxt_state != ST_STOP);
         keep_tick_osc <= (nxt_state == ST_STOP) &
                          (wdt_enabled | tick_enabled);
         // interrupt served only after clock restored
         irq_grant <= (state_ff == ST_RESTORE) & (nxt_state == ST_RUN) &
                      irq_s;
         mem_ctrl_reset_hold <= soft_reset_pulse | soft_reset_request_bit_ff;
         sys_clk_select <= sck_sel_ff;
      end
   end

   // ==========================================================
   // read data
   // decoded from the address phase so data stands for the whole data phase
   always @* begin
      case (haddr)
         `LPM_ADDR_POWER_CONTROL:
            rd_byte = {2'b00, soft_reset_request_bit_ff, 2'b00, emul_s, stop_bit_ff,
                       idle_bit_ff};
         `LPM_ADDR_IDLE_PEND: rd_byte = {1'b0, idle_pend_s};
         `LPM_ADDR_STOP_PEND: rd_byte = {1'b0, stop_wake_s};
         `LPM_ADDR_CLOCK_CONTROL: rd_byte = {7'h00, sck_sel_ff};
         default: rd_byte = `LPM_RESET_BYTE;
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         hrdata <= 32'h00000000;
      end else if (hsel & hready & htrans[1] & ~hwrite) begin
         hrdata <= {24'h000000, rd_byte};
      end
   end
endmodule

// ===== verilog/lpm_defs.vh
// Purpose: constants for the low power mode controller
// Assumes: ahb-lite word addressing of 8-bit registers
// Notes: register indexes are not word aligned, byte address is 4x index
`ifndef LPM_DEFS_VH
`define LPM_DEFS_VH
`define LPM_IDX_POWER_CONTROL 8'h87
`define LPM_IDX_IDLE_PEND 8'h8e
`define LPM_IDX_STOP_PEND 8'h8f
`define LPM_IDX_CLOCK_CONTROL 8'hc8
`define LPM_ADDR_POWER_CONTROL 12'h21c
`define LPM_ADDR_IDLE_PEND 12'h238
`define LPM_ADDR_STOP_PEND 12'h23c
`define LPM_ADDR_CLOCK_CONTROL 12'h320
`define LPM_BIT_IDLE 0
`define LPM_BIT_STOP 1
`define LPM_BIT_EMUL 2
`define LPM_BIT_SOFT_RESET_REQUEST 5
`define LPM_BIT_SCKSEL 0
`define LPM_RESET_BYTE 8'h00
`define LPM_STOP_OFF_CYCLES 2
`define LPM_RESTORE_CYCLES 2
`define LPM_SOFT_RESET_REQUEST_CYCLES 4
`endif

// ===== verilog/lpm_sync2.v
// Purpose: two flip-flop synchroniser for a bus of levels
// Assumes: inputs asynchronous to ref_clk
// Notes: first stage read only by second stage
`timescale 1ns/10ps
module lpm_sync2 #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // data
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_ff;

   always @(posedge ref_clk) begin
      if (reset) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule
